// *** rtl/scr_pkg.sv ***
// Constants, field layouts and carrier types of the sensor configuration register bank
package scr_pkg;
    // Byte register offsets
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h07;
    localparam logic [7:0] ADDR_WAKE_LOW = 8'h08;
    localparam logic [7:0] ADDR_WAKE_HIGH = 8'h09;
    localparam logic [7:0] ADDR_EMIT_PAIR = 8'h0f;
    localparam logic [7:0] ADDR_EMIT_THIRD = 8'h10;
    // Relocated interval decode of the early sequencer revision: low byte at 0x0A, high byte at 0x08
    localparam logic [7:0] ADDR_LEGACY_WAKE_LOW = 8'h0a;
    localparam logic [7:0] ADDR_LEGACY_WAKE_HIGH = 8'h08;

    // Reset values
    localparam logic [7:0] RST_UNLOCK_KEY = 8'h00;
    localparam logic [7:0] RST_WAKE_LOW = 8'h00;
    localparam logic [7:0] RST_WAKE_HIGH = 8'h00;
    localparam logic [7:0] RST_EMIT_PAIR = 8'h00;
    localparam logic [7:0] RST_EMIT_THIRD = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Key value that unlocks the device
    localparam logic [7:0] UNLOCK_VALUE = 8'h17;

    // Field positions
    localparam int DRIVE_W = 4;
    localparam int PAIR_SECOND_LSB = 4;
    localparam int PAIR_FIRST_LSB = 0;
    localparam int THIRD_LSB = 0;
    localparam logic [7:0] THIRD_WRITE_MASK = 8'h0f;
    localparam logic [3:0] DRIVE_OFF = 4'h0;

    // Channel list: bits 0..2 are the three proximity channels, bit 3 the light channel
    localparam int CHAN_W = 4;
    localparam int CHAN_IDX_W = 2;
    localparam int PROX_CHANNELS = 3;

    // Wake interval unit and its cycle count at 200 MHz
    localparam int WAKE_UNIT_NS = 31250;
    localparam int CLK_PERIOD_NS = 5;
    localparam int WAKE_UNIT_CYCLES = WAKE_UNIT_NS / CLK_PERIOD_NS;

    // Register access carried from the serial front end
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scr_reg_req_s;

    // Emitter drive codes as presented to the current sinks
    typedef struct packed {
        logic [3:0] third;
        logic [3:0] second;
        logic [3:0] first;
    } scr_drive_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SCAN,
        SEQ_BUSY
    } scr_seq_e;
endpackage

// *** rtl/scr_wake_timer.sv ***
// Autonomous wake-up timer counting interval units
`timescale 1ns/1ps
module scr_wake_timer #(
    parameter int TICK_CYCLES = 6250
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Control
    input wire logic restart_in,
    input wire logic [15:0] interval_in,
    // Wake event
    output logic wake_out
);
    logic [15:0] tick_count;
    logic [15:0] unit_count;
    logic [15:0] next_tick_count;
    logic [15:0] next_unit_count;
    logic next_wake;

    always_comb begin
        next_tick_count = tick_count;
        next_unit_count = unit_count;
        next_wake = 1'b0;
        // A zero interval stops autonomous operation
        if (restart_in || interval_in == 16'h0000) begin
            next_tick_count = 16'h0000;
            next_unit_count = 16'h0000;
        end else if (tick_count == 16'(TICK_CYCLES - 1)) begin
            next_tick_count = 16'h0000;
            if (unit_count + 16'h0001 >= interval_in) begin
                next_unit_count = 16'h0000;
                next_wake = 1'b1;
            end else begin
                next_unit_count = unit_count + 16'h0001;
            end
        end else begin
            next_tick_count = tick_count + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tick_count <= 16'h0000;
            unit_count <= 16'h0000;
            wake_out <= 1'b0;
        end else begin
            tick_count <= next_tick_count;
            unit_count <= next_unit_count;
            wake_out <= next_wake;
        end
    end
endmodule

// *** rtl/scr_config_regs.sv ***
// Configuration register bank: unlock key, wake interval, emitter currents and wake sequencer
// Function
// - Interval low byte gives bits 7..0, high byte bits 15..8.
// - Wake-ups are spaced by interval times 31.25 microseconds.
// - Each wake-up in idle runs every listed measurement, then waits again.
// - Early revision decodes interval low at 0x0A, high at 0x08.
// - Drive code 0 is off, 1 minimum, 15 maximum current.
// - Pair register bits 7:4 set the second emitter current.
// - Pair register bits 3:0 set the first emitter current.
// - Third register bits 3:0 set third emitter; upper bits reserved.
`timescale 1ns/1ps
module scr_config_regs
    import scr_pkg::*;
#(
    parameter int TICK_CYCLES = WAKE_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Byte register access from the serial front end
    input wire scr_pkg::scr_reg_req_s reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Emulation strap for the early sequencer revision
    input wire logic legacy_map_in,
    // Measurement engine
    input wire logic [scr_pkg::CHAN_W-1:0] channel_selection_list_in,
    input wire logic meas_done_in,
    output logic meas_start_out,
    output logic [scr_pkg::CHAN_IDX_W-1:0] meas_channel_out,
    output logic seq_busy_out,
    // Emitter current sinks and status
    output scr_pkg::scr_drive_s drive_out,
    output logic unlocked_out,
    output logic [15:0] wake_interval_out
);
    import scr_pkg::*;

    logic [7:0] unlock_key;
    logic [7:0] wake_interval_low;
    logic [7:0] wake_interval_high;
    logic [7:0] emitter_current_pair;
    logic [7:0] emitter_current_third;
    logic [7:0] next_unlock_key;
    logic [7:0] next_wake_interval_low;
    logic [7:0] next_wake_interval_high;
    logic [7:0] next_emitter_current_pair;
    logic [7:0] next_emitter_current_third;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic [15:0] wake_interval;
    logic interval_written;
    logic [7:0] low_addr;
    logic [7:0] high_addr;
    logic wake;

    // Register decode
    always_comb begin
        low_addr = legacy_map_in ? ADDR_LEGACY_WAKE_LOW : ADDR_WAKE_LOW;
        high_addr = legacy_map_in ? ADDR_LEGACY_WAKE_HIGH : ADDR_WAKE_HIGH;
        next_unlock_key = unlock_key;
        next_wake_interval_low = wake_interval_low;
        next_wake_interval_high = wake_interval_high;
        next_emitter_current_pair = emitter_current_pair;
        next_emitter_current_third = emitter_current_third;
        interval_written = 1'b0;
        if (reg_req_in.wr) begin
            if (reg_req_in.addr == ADDR_UNLOCK_KEY) begin
                next_unlock_key = reg_req_in.wdata;
            end
            if (reg_req_in.addr == low_addr) begin
                next_wake_interval_low = reg_req_in.wdata;
                interval_written = 1'b1;
            end
            if (reg_req_in.addr == high_addr) begin
                next_wake_interval_high = reg_req_in.wdata;
                interval_written = 1'b1;
            end
            if (reg_req_in.addr == ADDR_EMIT_PAIR) begin
                next_emitter_current_pair = reg_req_in.wdata;
            end
            if (reg_req_in.addr == ADDR_EMIT_THIRD) begin
                next_emitter_current_third = reg_req_in.wdata & THIRD_WRITE_MASK;
            end
        end
        next_rvalid = reg_req_in.rd;
        next_rdata = UNMAPPED_READ;
        if (reg_req_in.rd) begin
            if (reg_req_in.addr == ADDR_UNLOCK_KEY) begin
                next_rdata = unlock_key;
            end else if (reg_req_in.addr == low_addr) begin
                next_rdata = wake_interval_low;
            end else if (reg_req_in.addr == high_addr) begin
                next_rdata = wake_interval_high;
            end else if (reg_req_in.addr == ADDR_EMIT_PAIR) begin
                next_rdata = emitter_current_pair;
            end else if (reg_req_in.addr == ADDR_EMIT_THIRD) begin
                next_rdata = emitter_current_third & THIRD_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            unlock_key <= RST_UNLOCK_KEY;
            wake_interval_low <= RST_WAKE_LOW;
            wake_interval_high <= RST_WAKE_HIGH;
            emitter_current_pair <= RST_EMIT_PAIR;
            emitter_current_third <= RST_EMIT_THIRD;
            reg_rdata_out <= UNMAPPED_READ;
            reg_rvalid_out <= 1'b0;
        end else begin
            unlock_key <= next_unlock_key;
            wake_interval_low <= next_wake_interval_low;
            wake_interval_high <= next_wake_interval_high;
            emitter_current_pair <= next_emitter_current_pair;
            emitter_current_third <= next_emitter_current_third;
            reg_rdata_out <= next_rdata;
            reg_rvalid_out <= next_rvalid;
        end
    end

    assign wake_interval = {wake_interval_high, wake_interval_low};

    // A new interval restarts the count so the first wake follows one full interval
    scr_wake_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wake_timer (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .restart_in(interval_written),
        .interval_in(wake_interval),
        .wake_out(wake)
    );

    // Wake sequencer
    scr_seq_e state;
    scr_seq_e next_state;
    logic [CHAN_W-1:0] pending;
    logic [CHAN_W-1:0] next_pending;
    logic [CHAN_IDX_W-1:0] next_channel;
    logic next_start;
    scr_drive_s next_drive;
    logic [CHAN_IDX_W-1:0] lowest;
    logic unlocked;

    always_comb begin
        lowest = '0;
        for (int i = CHAN_W - 1; i >= 0; i--) begin
            if (pending[i]) begin
                lowest = CHAN_IDX_W'(i);
            end
        end
        unlocked = (unlock_key == UNLOCK_VALUE);
        next_state = state;
        next_pending = pending;
        next_channel = meas_channel_out;
        next_start = 1'b0;
        next_drive = '{third: DRIVE_OFF, second: DRIVE_OFF, first: DRIVE_OFF};
        case (state)
            SEQ_IDLE: begin
                // Wakes landing mid-scan are dropped; the scan finishes first
                if (wake) begin
                    next_pending = channel_selection_list_in;
                    next_state = SEQ_SCAN;
                end
            end
            SEQ_SCAN: begin
                if (pending == '0) begin
                    next_state = SEQ_IDLE;
                end else begin
                    next_channel = lowest;
                    next_start = 1'b1;
                    next_state = SEQ_BUSY;
                end
            end
            SEQ_BUSY: begin
                if (int'(meas_channel_out) < PROX_CHANNELS) begin
                    next_drive.first = emitter_current_pair[PAIR_FIRST_LSB +: DRIVE_W];
                    next_drive.second = emitter_current_pair[PAIR_SECOND_LSB +: DRIVE_W];
                    next_drive.third = emitter_current_third[THIRD_LSB +: DRIVE_W];
                end
                if (meas_done_in) begin
                    next_pending[meas_channel_out] = 1'b0;
                    next_drive = '{third: DRIVE_OFF, second: DRIVE_OFF, first: DRIVE_OFF};
                    next_state = SEQ_SCAN;
                end
            end
            default: begin
                next_state = SEQ_IDLE;
                next_pending = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state <= SEQ_IDLE;
            pending <= '0;
            meas_channel_out <= '0;
            meas_start_out <= 1'b0;
            seq_busy_out <= 1'b0;
            drive_out <= '{third: DRIVE_OFF, second: DRIVE_OFF, first: DRIVE_OFF};
            unlocked_out <= 1'b0;
            wake_interval_out <= 16'h0000;
        end else begin
            state <= next_state;
            pending <= next_pending;
            meas_channel_out <= next_channel;
            meas_start_out <= next_start;
            seq_busy_out <= (next_state != SEQ_IDLE);
            drive_out <= next_drive;
            unlocked_out <= unlocked;
            wake_interval_out <= wake_interval;
        end
    end
endmodule

// *** sim/scr_config_regs_asserts.sv ***
// Port-level assertions for the configuration register bank
`timescale 1ns/1ps
module scr_config_regs_asserts
    import scr_pkg::*;
#(
    parameter int TICK_CYCLES = 4
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire scr_pkg::scr_reg_req_s reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic legacy_map_in,
    input wire logic meas_done_in,
    input wire logic meas_start_out,
    input wire logic [scr_pkg::CHAN_IDX_W-1:0] meas_channel_out,
    input wire logic seq_busy_out,
    input wire scr_pkg::scr_drive_s drive_out,
    input wire logic unlocked_out,
    input wire logic [15:0] wake_interval_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_meas_end;
        meas_done_in && seq_busy_out;
    endsequence
    sequence s_release;
        drive_out == '0 ##1 (meas_start_out || !seq_busy_out);
    endsequence
    property p_read_answer;
        reg_req_in.rd |=> reg_rvalid_out;
    endproperty
    property p_read_quiet;
        !reg_req_in.rd |=> !reg_rvalid_out && reg_rdata_out == 8'h00;
    endproperty
    property p_key;
        reg_req_in.wr && reg_req_in.addr == ADDR_UNLOCK_KEY
            |=> ##1 unlocked_out == ($past(reg_req_in.wdata, 2) == UNLOCK_VALUE);
    endproperty
    property p_low;
        reg_req_in.wr && reg_req_in.addr == (legacy_map_in ? ADDR_LEGACY_WAKE_LOW : ADDR_WAKE_LOW)
            |=> ##1 wake_interval_out[7:0] == $past(reg_req_in.wdata, 2);
    endproperty
    property p_high;
        reg_req_in.wr && reg_req_in.addr == (legacy_map_in ? ADDR_LEGACY_WAKE_HIGH : ADDR_WAKE_HIGH)
            |=> ##1 wake_interval_out[15:8] == $past(reg_req_in.wdata, 2);
    endproperty
    property p_third_rsv;
        reg_req_in.rd && reg_req_in.addr == ADDR_EMIT_THIRD |=> reg_rdata_out[7:4] == 4'h0;
    endproperty
    property p_idle_drive;
        !seq_busy_out |-> drive_out == '0;
    endproperty
    property p_start;
        meas_start_out |-> seq_busy_out ##1 !meas_start_out;
    endproperty
    property p_release;
        s_meas_end |=> s_release;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    a_read_quiet: assert property (p_read_quiet) else $error("read data without read");
    a_key: assert property (p_key) else $error("unlock flag wrong");
    a_low: assert property (p_low) else $error("interval low byte wrong");
    a_high: assert property (p_high) else $error("interval high byte wrong");
    a_third_rsv: assert property (p_third_rsv) else $error("reserved bits not zero");
    a_idle_drive: assert property (p_idle_drive) else $error("drive while idle");
    a_start: assert property (p_start) else $error("start outside scan");
    a_release: assert property (p_release) else $error("drive not released");
endmodule
bind scr_config_regs scr_config_regs_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .legacy_map_in(legacy_map_in), .meas_done_in(meas_done_in),
    .meas_start_out(meas_start_out), .meas_channel_out(meas_channel_out), .seq_busy_out(seq_busy_out),
    .drive_out(drive_out), .unlocked_out(unlocked_out), .wake_interval_out(wake_interval_out));

// *** sim/scr_host_model.sv ***
// Host model issuing byte register accesses
`timescale 1ns/1ps
module scr_host_model
    import scr_pkg::*;
#(
    parameter int EMITTERS = 3
) (
    // Clock
    input wire logic sys_clk_in,
    // Register port
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    output scr_pkg::scr_reg_req_s req_out
);
    initial req_out = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // Smaller variants keep unused emitter fields off
        if (a == ADDR_EMIT_PAIR && EMITTERS < 2) v[7:4] = 4'h0;
        if (a == ADDR_EMIT_THIRD && EMITTERS < 3) v[3:0] = 4'h0;
        @(posedge sys_clk_in);
        #1 req_out = '{a, v, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        #1 req_out = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk_in);
        #1 req_out = '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        #1 req_out = '0;
        d = rdata_in;
        v = rvalid_in;
    endtask
    task automatic unlock;
        wr(ADDR_UNLOCK_KEY, UNLOCK_VALUE);
    endtask
endmodule

// *** sim/scr_config_regs_tb.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module scr_config_regs_tb;
    import scr_pkg::*;
    localparam int TICK = 4;
    logic sys_clk_in = 0;
    logic reset_in = 1;
    logic legacy_map_in = 0;
    logic meas_done_in = 0;
    logic chk_drive = 0;
    logic busy_d = 0;
    logic [3:0] chan_list = 4'hb;
    logic [7:0] key = 0, lo = 0, hi = 0, pair = 0, third = 0, got, a;
    logic [7:0] tbl [7] = '{8'h07, 8'h08, 8'h09, 8'h0f, 8'h10, 8'h0a, 8'h55};
    logic [3:0] codes [3] = '{4'h0, 4'h1, 4'hf};
    logic v, rvalid, start, busy, unl;
    logic [7:0] rdata;
    logic [1:0] ch;
    logic [15:0] wint;
    scr_reg_req_s req;
    scr_drive_s drive;
    int failures = 0, n_compared = 0, cycles = 0, seed = 32'h63d0_25a0;
    int k, prev = -1, last_rise = 0, gap = 0;
    scr_config_regs #(.TICK_CYCLES(TICK)) dut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .legacy_map_in(legacy_map_in), .channel_selection_list_in(chan_list),
        .meas_done_in(meas_done_in), .meas_start_out(start), .meas_channel_out(ch), .seq_busy_out(busy),
        .drive_out(drive), .unlocked_out(unl), .wake_interval_out(wint));
    scr_host_model host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
    initial forever #2.5 sys_clk_in = ~sys_clk_in;
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t reg got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_seq(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t out got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [7:0] model_rd(input logic [7:0] ad, input logic lg);
        case (ad)
            8'h07: return key;
            8'h08: return lg ? hi : lo;
            8'h09: return lg ? 8'h00 : hi;
            8'h0a: return lg ? lo : 8'h00;
            8'h0f: return pair;
            8'h10: return third;
            default: return 8'h00;
        endcase
    endfunction
    task automatic acc(input logic [7:0] ad, input logic [7:0] d, input logic lg);
        legacy_map_in = lg;
        host.wr(ad, d);
        if (ad == 8'h07) key = d;
        if (ad == (lg ? 8'h0a : 8'h08)) lo = d;
        if (ad == (lg ? 8'h08 : 8'h09)) hi = d;
        if (ad == 8'h0f) pair = d;
        if (ad == 8'h10) third = d & 8'h0f;
        host.rd(ad, got, v);
        cmp_reg(got, model_rd(ad, lg));
        cmp_seq(16'(v), 16'd1);
        // Status outputs trail the register by one cycle
        cmp_seq(wint, {hi, lo});
        cmp_seq(16'(unl), 16'(key == 8'h17));
    endtask
    // Measurement engine: answers each start after a random stall
    always @(posedge sys_clk_in) begin
        if (start === 1'b1) begin
            for (k = prev + 1; k < 3 && !chan_list[k]; k++);
            cmp_seq(16'(ch), 16'(k));
            prev = k;
            #1;
            if (chk_drive) cmp_seq(16'(drive), k == 3 ? 16'h0000 : {4'h0, third[3:0], pair});
            repeat ($random(seed) & 3) @(posedge sys_clk_in);
            #1 meas_done_in = 1;
            @(posedge sys_clk_in);
            #1 meas_done_in = 0;
        end
    end
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
        if (busy === 1'b1 && !busy_d) begin
            gap = cycles - last_rise;
            last_rise = cycles;
            prev = -1;
        end
        busy_d = busy;
    end
    initial begin
        repeat (16) @(posedge sys_clk_in);
        #1 reset_in = 0;
        foreach (tbl[i]) begin
            host.rd(tbl[i], got, v);
            cmp_reg(got, 8'h00);
        end
        host.unlock();
        key = 8'h17;
        @(posedge sys_clk_in);
        #1 cmp_seq(16'(unl), 16'd1);
        repeat (40) begin
            a = tbl[$unsigned($random(seed)) % 7];
            acc(a, 8'($random(seed)), 1'($random(seed)));
        end
        acc(8'h08, 8'h00, 0);
        acc(8'h09, 8'h00, 0);
        repeat (40) @(posedge sys_clk_in);
        chan_list = 4'h1;
        acc(8'h08, 8'h03, 0);
        repeat (40) @(posedge sys_clk_in);
        cmp_seq(16'(gap), 16'(3 * TICK));
        // Interval off before changing codes so no scan sees a half update
        foreach (codes[i]) begin
            acc(8'h08, 8'h00, 0);
            repeat (30) @(posedge sys_clk_in);
            chan_list = 4'hf;
            chk_drive = 1;
            acc(8'h0f, {codes[i], ~codes[i]}, 0);
            acc(8'h10, {4'h5, codes[i]}, 0);
            acc(8'h08, 8'h08, 0);
            repeat (90) @(posedge sys_clk_in);
        end
        stop_test();
    end
endmodule
